// File: rtl/rcbm_map.svh
// offsets, counts and reset values for the configuration byte mapper
`ifndef RCBM_MAP_SVH
`define RCBM_MAP_SVH
// image layout
`define RCBM_FIRST_CFG_INDEX 8'h03
`define RCBM_BYTES_PER_DEVICE 6'h25
// image byte indices in the single-device layout
`define RCBM_IDX_05 8'h05
`define RCBM_IDX_06 8'h06
`define RCBM_IDX_07 8'h07
`define RCBM_IDX_08 8'h08
`define RCBM_IDX_09 8'h09
`define RCBM_IDX_0A 8'h0A
`define RCBM_IDX_0B 8'h0B
`define RCBM_IDX_0C 8'h0C
`define RCBM_IDX_0D 8'h0D
`define RCBM_IDX_0E 8'h0E
`define RCBM_IDX_0F 8'h0F
`define RCBM_IDX_10 8'h10
// internal register offsets
`define RCBM_REG_04 5'h04
`define RCBM_REG_06 5'h06
`define RCBM_REG_08 5'h08
`define RCBM_REG_0B 5'h0B
`define RCBM_REG_0E 5'h0E
`define RCBM_REG_0F 5'h0F
`define RCBM_REG_10 5'h10
`define RCBM_REG_11 5'h11
`define RCBM_REG_12 5'h12
`define RCBM_REG_15 5'h15
`define RCBM_REG_16 5'h16
`define RCBM_REG_17 5'h17
`define RCBM_REG_18 5'h18
`define RCBM_REG_19 5'h19
`define RCBM_REG_1C 5'h1C
`define RCBM_REG_1D 5'h1D
`define RCBM_REG_1E 5'h1E
// power-on value of every internal register bit
`define RCBM_REG_POR 8'h00
`endif

// File: rtl/rcbm_pkg.sv
// types for the configuration byte mapper
package rcbm_pkg;
  typedef enum logic [1:0]
  {
    RCBM_IDLE = 2'b00,
    RCBM_FETCH = 2'b01,
    RCBM_DONE = 2'b10
  } rcbm_state_t;
endpackage

// File: rtl/rcbm_mapper.sv
// configuration byte loader and bit mapper for the repeater control registers
`timescale 1ns/100ps
`include "rcbm_map.svh"
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module rcbm_mapper #(
  parameter int ADDR_W = 10
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // load chain
  input wire logic read_en_n,
  input wire logic chain_done,
  input wire logic [ADDR_W-1:0] cfg_base_addr,
  output logic all_done,
  output logic bus_master,
  // byte fetch from the serial memory reader
  output logic fetch_req,
  output logic [ADDR_W-1:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_data,
  // register read port
  input wire logic [4:0] reg_rd_addr,
  output logic [7:0] reg_rd_data
);

  rcbm_pkg::rcbm_state_t state_q;
  logic [5:0] count_q;
  // register image by internal offset
  logic [7:0] regs_q [0:31];
  logic [7:0] idx;
  logic [7:0] b;

  // ----------------------------------------------------------------------------
  // load sequencer
  // ----------------------------------------------------------------------------
  // layout index of the byte now at fetch_addr
  assign idx = `RCBM_FIRST_CFG_INDEX + {2'h0, count_q};
  assign b = fetch_data;
  assign fetch_req = (state_q == rcbm_pkg::RCBM_FETCH);
  assign fetch_addr = cfg_base_addr + ADDR_W'(count_q);

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_q <= rcbm_pkg::RCBM_IDLE;
      count_q <= 6'h00;
    end
    else if (clk_en)
    begin
      case (state_q)
        rcbm_pkg::RCBM_IDLE:
        begin
          if (!read_en_n)
          begin
            state_q <= rcbm_pkg::RCBM_FETCH;
            count_q <= 6'h00;
          end
        end
        // a byte counts only on an enabled edge that carries valid
        rcbm_pkg::RCBM_FETCH:
        begin
          if (fetch_valid)
          begin
            if (count_q == `RCBM_BYTES_PER_DEVICE - 6'h01)
            begin
              state_q <= rcbm_pkg::RCBM_DONE;
            end
            count_q <= count_q + 6'h01;
          end
        end
        // done holds; the spare code parks there too
        default:
        begin
          state_q <= rcbm_pkg::RCBM_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      all_done <= 1'h0;
      bus_master <= 1'h1;
    end
    else if (clk_en)
    begin
      all_done <= (state_q == rcbm_pkg::RCBM_DONE);
      // release is sticky until reset, even in mid-load
      if (chain_done)
      begin
        bus_master <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // bit mapping into the register image
  // ----------------------------------------------------------------------------
  // unmapped bytes and uncovered bits leave the image alone
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 32; i++)
      begin
        regs_q[i] <= `RCBM_REG_POR;
      end
    end
    else if (clk_en && fetch_req && fetch_valid)
    begin
      if (idx == `RCBM_IDX_05)
      begin
        regs_q[`RCBM_REG_04][4:0] <= b[7:3];
        regs_q[`RCBM_REG_06][4] <= b[2];
        regs_q[`RCBM_REG_08][6] <= b[1];
        regs_q[`RCBM_REG_08][5] <= b[0];
      end
      else if (idx == `RCBM_IDX_06)
      begin
        regs_q[`RCBM_REG_08][4] <= b[7];
        regs_q[`RCBM_REG_08][3] <= b[6];
        regs_q[`RCBM_REG_08][2:0] <= b[5:3];
        regs_q[`RCBM_REG_0B][6:4] <= b[2:0];
      end
      else if (idx == `RCBM_IDX_07)
      begin
        regs_q[`RCBM_REG_0B][3:0] <= b[7:4];
        regs_q[`RCBM_REG_0E][5:4] <= b[3:2];
        regs_q[`RCBM_REG_0E][3:2] <= b[1:0];
      end
      else if (idx == `RCBM_IDX_08)
      begin
        regs_q[`RCBM_REG_0F] <= b;
      end
      else if (idx == `RCBM_IDX_09)
      begin
        regs_q[`RCBM_REG_10] <= b;
      end
      else if (idx == `RCBM_IDX_0A)
      begin
        regs_q[`RCBM_REG_11][2:0] <= b[7:5];
        regs_q[`RCBM_REG_12][7] <= b[4];
        regs_q[`RCBM_REG_12][3:0] <= b[3:0];
      end
      else if (idx == `RCBM_IDX_0B)
      begin
        regs_q[`RCBM_REG_15][5:4] <= b[7:6];
        regs_q[`RCBM_REG_15][3:2] <= b[5:4];
        regs_q[`RCBM_REG_16][7:4] <= b[3:0];
      end
      else if (idx == `RCBM_IDX_0C)
      begin
        regs_q[`RCBM_REG_16][3:2] <= b[7:6];
        regs_q[`RCBM_REG_16][1:0] <= b[5:4];
        regs_q[`RCBM_REG_17][7] <= b[3];
        regs_q[`RCBM_REG_17][6:4] <= b[2:0];
      end
      else if (idx == `RCBM_IDX_0D)
      begin
        regs_q[`RCBM_REG_17][3] <= b[7];
        regs_q[`RCBM_REG_17][2:0] <= b[6:4];
        regs_q[`RCBM_REG_18][2:0] <= b[3:1];
        regs_q[`RCBM_REG_19][7] <= b[0];
      end
      else if (idx == `RCBM_IDX_0E)
      begin
        regs_q[`RCBM_REG_19][3:0] <= b[7:4];
        regs_q[`RCBM_REG_1C][5:4] <= b[3:2];
        regs_q[`RCBM_REG_1C][3:2] <= b[1:0];
      end
      else if (idx == `RCBM_IDX_0F)
      begin
        regs_q[`RCBM_REG_1D] <= b;
      end
      else if (idx == `RCBM_IDX_10)
      begin
        regs_q[`RCBM_REG_1E] <= b;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------------------
  // one edge of latency, frozen with the clock enable
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      reg_rd_data <= 8'h00;
    end
    else if (clk_en)
    begin
      reg_rd_data <= regs_q[reg_rd_addr];
    end
  end

endmodule

// File: tb/rcbm_assertions.sv
// port assertions for the byte mapper
`timescale 1ns/100ps
module rcbm_assertions #(
  parameter int ADDR_W = 10
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // load chain
  input wire logic chain_done,
  input wire logic [ADDR_W-1:0] cfg_base_addr,
  input wire logic all_done,
  input wire logic bus_master,
  // byte fetch
  input wire logic fetch_req,
  input wire logic [ADDR_W-1:0] fetch_addr,
  input wire logic fetch_valid,
  // register read port
  input wire logic [7:0] reg_rd_data
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_take;
    fetch_req && fetch_valid && clk_en;
  endsequence
  a_bus_free: assert property (chain_done && clk_en |=> !bus_master) else $error("bus kept");
  a_bus_held: assert property (!bus_master |=> !bus_master) else $error("bus taken");
  a_done_held: assert property (all_done |=> all_done && !fetch_req) else $error("done lost");
  a_addr_hold: assert property (fetch_req && !fetch_valid |=> $stable(fetch_addr)) else $error("addr moved");
  a_addr_step: assert property (s_take |=> !fetch_req || fetch_addr == $past(fetch_addr) + 1'h1)
    else $error("step");
  a_first_addr: assert property ($rose(fetch_req) |-> fetch_addr == cfg_base_addr) else $error("base");
  a_last_addr: assert property (s_take ##1 !fetch_req |-> $past(fetch_addr) == ADDR_W'(cfg_base_addr + 6'h24))
    else $error("count");
  a_reset_state: assert property ($past(sys_rst) |-> reg_rd_data == 8'h00 && bus_master && !all_done)
    else $error("reset");
endmodule
bind rcbm_mapper rcbm_assertions #(
  .ADDR_W(ADDR_W)
) i_chk (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .clk_en(clk_en),
  .chain_done(chain_done),
  .cfg_base_addr(cfg_base_addr),
  .all_done(all_done),
  .bus_master(bus_master),
  .fetch_req(fetch_req),
  .fetch_addr(fetch_addr),
  .fetch_valid(fetch_valid),
  .reg_rd_data(reg_rd_data)
);

// File: tb/rcbm_mem_model.sv
// serial memory model answering byte fetches
`timescale 1ns/100ps
module rcbm_mem_model (
  // clock and pacing
  input wire logic ref_clk,
  input wire logic slow,
  // fetch port
  input wire logic fetch_req,
  input wire logic [9:0] fetch_addr,
  output logic fetch_valid = 1'h0,
  output logic [7:0] fetch_data = 8'h00
);
  logic [7:0] mem [1024];
  logic gap = 1'h0;
  // slow answers every other cycle; idle data keeps changing
  always @(posedge ref_clk)
  begin
    #1 gap = slow & ~gap;
    fetch_valid = fetch_req & ~gap;
    fetch_data = fetch_valid ? mem[fetch_addr] : ~fetch_data;
  end
endmodule

// File: tb/repeater_config_byte_mapper_test.sv
// self-checking bench for the byte mapper
`timescale 1ns/100ps
module repeater_config_byte_mapper_test;
  logic ref_clk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1, read_en_n = 1'h1, chain_done = 1'h0, slow = 1'h0;
  logic [9:0] cfg_base_addr = 10'h000, fetch_addr;
  logic all_done, bus_master, fetch_req, fetch_valid;
  logic [7:0] fetch_data, reg_rd_data;
  logic [31:0] [7:0] x;
  logic [4:0] reg_rd_addr = 5'h00;
  logic [3:39] [7:0] b;
  logic [31:0] lf = 32'h0001_3085;
  int failures = 0, n_tests = 0;
  wire [7:0] fl = {5'h00, fetch_req, all_done, bus_master};
  rcbm_mapper i_dut (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .read_en_n(read_en_n),
    .chain_done(chain_done),
    .cfg_base_addr(cfg_base_addr),
    .all_done(all_done),
    .bus_master(bus_master),
    .fetch_req(fetch_req),
    .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid),
    .fetch_data(fetch_data),
    .reg_rd_addr(reg_rd_addr),
    .reg_rd_data(reg_rd_data)
  );
  rcbm_mem_model i_mem (
    .ref_clk(ref_clk),
    .slow(slow),
    .fetch_req(fetch_req),
    .fetch_addr(fetch_addr),
    .fetch_valid(fetch_valid),
    .fetch_data(fetch_data)
  );
  initial
    forever #2 ref_clk = ~ref_clk;
  function automatic logic [31:0] step();
    return {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
  endfunction
  // expected register image: listed image bits in order land on their fields, all else zero
  function automatic logic [31:0] [7:0] exp_regs(logic [3:39] [7:0] img);
    logic [31:0] [7:0] e;
    e = {32{8'h00}};
    {e[4][4:0], e[6][4], e[8][6:0], e[11][6:0], e[14][5:2], e[15], e[16], e[17][2:0], e[18][7], e[18][3:0],
      e[21][5:2], e[22], e[23], e[24][2:0], e[25][7], e[25][3:0], e[28][5:2], e[29], e[30]} = img[5:16];
    return e;
  endfunction
  task automatic chk(string n, logic [7:0] ex, logic [7:0] got);
    n_tests++;
    if (got !== ex)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic rd();
    for (int r = 0; r < 32; r++)
    begin
      reg_rd_addr = 5'(r);
      @(posedge ref_clk);
      #1 chk("reg", x[r], reg_rd_data);
    end
  endtask
  task automatic run();
    sys_rst = 1'h1;
    read_en_n = 1'h1;
    repeat (4) @(posedge ref_clk);
    #1 sys_rst = 1'h0;
    cfg_base_addr = lf[9:0] & 10'h1FF;
    x = {32{8'h00}};
    rd();
    for (int i = 3; i < 40; i++)
    begin
      lf = step();
      b[i] = {8{slow}} | lf[7:0];
      i_mem.mem[cfg_base_addr + i - 3] = b[i];
    end
    x = exp_regs(b);
    read_en_n = 1'h0;
    for (int i = 0; i < 400 && all_done !== 1'h1; i++)
    begin
      @(posedge ref_clk);
      #1 lf = step();
      clk_en = lf[3] | lf[7] | all_done;
    end
    rd();
    chk("loaded", 8'h03, fl);
    chain_done = 1'h1;
    repeat (2) @(posedge ref_clk);
    #1 chain_done = 1'h0;
    chk("released", 8'h02, fl);
    $display("run done, slow %0d", slow);
  endtask
  initial
  begin
    run();
    slow = 1'h1;
    run();
    wrap_up();
  end
  initial
  begin
    #100000 failures++;
    wrap_up();
  end
endmodule
